// File: design/atcs_top.v
/*
  clock source selection, prescaler and asynchronous synchronisation for an
  8-bit timer: holding registers, busy flags, counter shadow, flag sync,
  sleep and wake handling, compare output.
  assumes: all inputs synchronous to core_clk_in; the oscillator pin level is
  sampled here, so the core clock must run well above the oscillator.
*/
// The implementer's own choices: the placing of the registers and the plain strobed port.
// Functional notes
// - sync mode: timer clock is an enable
// - async writes land after two oscillator edges
// - five registers each own holding register
// - status register shows per-register busy flags
// - compare match suppressed during compare/counter writes
// - re-entered sleep in same cycle wakes again
// - oscillator runs when async selected, except in power-down
// - timer registers lost after power-down wake
// - wake starts on next timer clock
// - counter read through shadow, refreshed per edge
// - flag sync: three cycles plus timer cycle
// - compare pin changes on timer clock
// - source defaults to I/O clock
// - oscillator pins detached when async selected
// - prescaler: stop, 1, 8..1024 selections
// - prescaler reset bit resets prescaler
`timescale 1ns/1ps
`include "atcs_regs.vh"

module atcs_top
(
  input wire core_clk_in,
  input wire nrst_in,
  input wire [7:0] addr_in,
  input wire [7:0] wr_data_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rd_data_out,
  input wire osc_input_pin_in,
  input wire sleep_in,
  input wire power_down_in,
  output reg osc_enable_out,
  output reg port_detach_out,
  output reg compare_out,
  output reg wake_out
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  reg rst_meta_q;
  reg rst_n_q;

  always @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  reg async_clock_select_q;
  reg osc_prev_q;
  reg [7:0] async_counter_value_q;
  reg [7:0] shadow_q;
  reg [2:0] flags_q;
  reg [2:0] irq_en_q;
  reg [2:0] ev_pipe_q [0:`ATCS_FLAG_SYNC_STAGES-1];
  reg wake_pend_q;
  reg lost_q;
  wire wr_cnt;
  wire wr_cmp_a;
  wire wr_cmp_b;
  wire wr_ctl_a;
  wire wr_ctl_b;
  wire osc_edge;
  wire src_en;
  wire tick;
  wire presc_clr;
  wire lost;
  wire [7:0] cnt_hold;
  wire [7:0] compare_value_a;
  wire [7:0] compare_value_b;
  wire [7:0] ctrl_a;
  wire [7:0] ctrl_b;
  wire counter_update_busy;
  wire compare_update_busy_a;
  wire compare_update_busy_b;
  wire control_update_busy_a;
  wire control_update_busy_b;
  wire cnt_xfer;
  wire cmp_block;
  wire match_a;
  wire match_b;
  wire ovf;
  wire [2:0] events;
  wire [2:0] flag_set;
  wire [2:0] flag_clr;
  wire [7:0] status;
  integer i;

  function is_wr;
    input [7:0] addr;
    input [7:0] off;
    input wr;
    begin
      is_wr = wr & (addr == off);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // clock source
  // the oscillator only runs when selected and not in a deep sleep mode
  always @(posedge core_clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      osc_enable_out <= 1'b0;
      port_detach_out <= 1'b0;
      osc_prev_q <= 1'b0;
    end
    else
    begin
      osc_enable_out <= async_clock_select_q & ~power_down_in;
      port_detach_out <= async_clock_select_q;
      osc_prev_q <= osc_input_pin_in;
    end
  end

  assign osc_edge = osc_input_pin_in & ~osc_prev_q & osc_enable_out;
  assign src_en = async_clock_select_q ? osc_edge : 1'b1;

  assign presc_clr = is_wr(addr_in, `ATCS_OFF_GEN_CTRL, wr_in) &
                     wr_data_in[`ATCS_GC_PRESC_RST];

  atcs_prescaler u_presc
  (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n_q),
    .src_en_in(src_en),
    .clr_in(presc_clr),
    .sel_in(ctrl_b[`ATCS_CB_CS_HI:`ATCS_CB_CS_LO]),
    .tick_out(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // holding registers, one each for counter, compare A/B and control A/B
  assign wr_cnt = is_wr(addr_in, `ATCS_OFF_COUNTER, wr_in);
  assign wr_cmp_a = is_wr(addr_in, `ATCS_OFF_COMPARE_A, wr_in);
  assign wr_cmp_b = is_wr(addr_in, `ATCS_OFF_COMPARE_B, wr_in);
  assign wr_ctl_a = is_wr(addr_in, `ATCS_OFF_CTRL_A, wr_in);
  assign wr_ctl_b = is_wr(addr_in, `ATCS_OFF_CTRL_B, wr_in);
  // entering power-down clears the timer registers to zero
  assign lost = power_down_in & ~lost_q;

  atcs_hold #(.W(8)) u_hold_cnt
  (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n_q),
    .lost_in(lost),
    .wr_in(wr_cnt),
    .wdata_in(wr_data_in),
    .async_in(async_clock_select_q),
    .osc_edge_in(osc_edge),
    .value_out(cnt_hold),
    .busy_out(counter_update_busy),
    .xfer_out(cnt_xfer)
  );

  atcs_hold #(.W(8)) u_hold_cmp_a
  (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n_q),
    .lost_in(lost),
    .wr_in(wr_cmp_a),
    .wdata_in(wr_data_in),
    .async_in(async_clock_select_q),
    .osc_edge_in(osc_edge),
    .value_out(compare_value_a),
    .busy_out(compare_update_busy_a),
    .xfer_out()
  );

  atcs_hold #(.W(8)) u_hold_cmp_b
  (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n_q),
    .lost_in(lost),
    .wr_in(wr_cmp_b),
    .wdata_in(wr_data_in),
    .async_in(async_clock_select_q),
    .osc_edge_in(osc_edge),
    .value_out(compare_value_b),
    .busy_out(compare_update_busy_b),
    .xfer_out()
  );

  atcs_hold #(.W(8)) u_hold_ctl_a
  (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n_q),
    .lost_in(lost),
    .wr_in(wr_ctl_a),
    .wdata_in(wr_data_in),
    .async_in(async_clock_select_q),
    .osc_edge_in(osc_edge),
    .value_out(ctrl_a),
    .busy_out(control_update_busy_a),
    .xfer_out()
  );

  atcs_hold #(.W(8)) u_hold_ctl_b
  (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n_q),
    .lost_in(lost),
    .wr_in(wr_ctl_b),
    .wdata_in(wr_data_in),
    .async_in(async_clock_select_q),
    .osc_edge_in(osc_edge),
    .value_out(ctrl_b),
    .busy_out(control_update_busy_b),
    .xfer_out()
  );

  ////////////////////////////////////////////////////////////////////////////
  // counter and compare units, all stepping on the timer tick
  // a half-written compare value or counter must not produce a spurious match
  assign cmp_block = counter_update_busy | compare_update_busy_a |
                     compare_update_busy_b | cnt_xfer;
  assign match_a = tick & ~cmp_block & (async_counter_value_q == compare_value_a);
  assign match_b = tick & ~cmp_block & (async_counter_value_q == compare_value_b);
  assign ovf = tick & (async_counter_value_q == 8'hff) &
               ~(match_a & ctrl_a[`ATCS_CA_CTC]);
  assign events = {match_b, match_a, ovf};

  always @(posedge core_clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      async_counter_value_q <= `ATCS_RST_BYTE;
      compare_out <= 1'b0;
      lost_q <= 1'b0;
    end
    else
    begin
      lost_q <= power_down_in;
      if (lost)
      begin
        async_counter_value_q <= `ATCS_RST_BYTE;
        compare_out <= 1'b0;
      end
      else if (cnt_xfer)
      begin
        async_counter_value_q <= cnt_hold;
      end
      else if (tick)
      begin
        if (match_a && ctrl_a[`ATCS_CA_CTC])
        begin
          async_counter_value_q <= 8'h00;
        end
        else
        begin
          async_counter_value_q <= async_counter_value_q + 8'h01;
        end
        // pin follows the timer tick directly, with no flag-style sync stages
        if (match_a)
        begin
          case (ctrl_a[`ATCS_CA_COM_HI:`ATCS_CA_COM_LO])
            `ATCS_COM_TOGGLE: compare_out <= ~compare_out;
            `ATCS_COM_CLEAR: compare_out <= 1'b0;
            `ATCS_COM_SET: compare_out <= 1'b1;
            default: compare_out <= compare_out;
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter shadow: in async mode no refresh while the core sleeps, so it reads stale after
  // wake until the next oscillator edge
  always @(posedge core_clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      shadow_q <= `ATCS_RST_BYTE;
    end
    else if (!async_clock_select_q)
    begin
      shadow_q <= async_counter_value_q;
    end
    else if (osc_edge && !sleep_in)
    begin
      shadow_q <= async_counter_value_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt flags: async events take extra core cycles to land
  always @(posedge core_clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      for (i = 0; i < `ATCS_FLAG_SYNC_STAGES; i = i + 1)
      begin
        ev_pipe_q[i] <= 3'h0;
      end
    end
    else
    begin
      ev_pipe_q[0] <= async_clock_select_q ? events : 3'h0;
      for (i = 1; i < `ATCS_FLAG_SYNC_STAGES; i = i + 1)
      begin
        ev_pipe_q[i] <= ev_pipe_q[i-1];
      end
    end
  end

  assign flag_set = async_clock_select_q ? ev_pipe_q[`ATCS_FLAG_SYNC_STAGES-1] : events;
  assign flag_clr = is_wr(addr_in, `ATCS_OFF_FLAGS, wr_in) ? wr_data_in[2:0] : 3'h0;

  always @(posedge core_clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      flags_q <= 3'h0;
      irq_en_q <= 3'h0;
      async_clock_select_q <= 1'b0;
    end
    else
    begin
      // a new event beats a clear in the same cycle
      flags_q <= (flags_q & ~flag_clr) | flag_set;
      if (is_wr(addr_in, `ATCS_OFF_IRQ_EN, wr_in))
      begin
        irq_en_q <= wr_data_in[2:0];
      end
      if (is_wr(addr_in, `ATCS_OFF_STATUS, wr_in))
      begin
        async_clock_select_q <= wr_data_in[`ATCS_ST_ASYNC_SEL];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake: a pending enabled flag is taken up at the next timer clock and
  // stays up, so sleeping again before it is cleared wakes at once
  always @(posedge core_clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      wake_pend_q <= 1'b0;
      wake_out <= 1'b0;
    end
    else
    begin
      wake_pend_q <= |(flags_q & irq_en_q);
      if (!wake_pend_q)
      begin
        wake_out <= 1'b0;
      end
      else if (src_en)
      begin
        wake_out <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read
  assign status = {2'h0, async_clock_select_q, counter_update_busy,
                   compare_update_busy_a, compare_update_busy_b,
                   control_update_busy_a, control_update_busy_b};

  always @(posedge core_clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      rd_data_out <= 8'h00;
    end
    else if (rd_in)
    begin
      case (addr_in)
        `ATCS_OFF_COUNTER: rd_data_out <= shadow_q;
        `ATCS_OFF_COMPARE_A: rd_data_out <= compare_value_a;
        `ATCS_OFF_COMPARE_B: rd_data_out <= compare_value_b;
        `ATCS_OFF_CTRL_A: rd_data_out <= ctrl_a;
        `ATCS_OFF_CTRL_B: rd_data_out <= ctrl_b;
        `ATCS_OFF_STATUS: rd_data_out <= status;
        `ATCS_OFF_FLAGS: rd_data_out <= {5'h00, flags_q};
        `ATCS_OFF_IRQ_EN: rd_data_out <= {5'h00, irq_en_q};
        default: rd_data_out <= 8'h00;
      endcase
    end
    else
    begin
      rd_data_out <= 8'h00;
    end
  end

endmodule

// File: inc/atcs_regs.vh
/*
  register offsets, field positions, reset values and timing counts of the
  asynchronous timer clock and synchronisation block.
  assumes: included by bare name from the design files.
*/
`ifndef ATCS_REGS_VH
`define ATCS_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// register offsets (byte addresses, one word each)
`define ATCS_ADDR_W 8
`define ATCS_OFF_COUNTER 8'h00
`define ATCS_OFF_COMPARE_A 8'h04
`define ATCS_OFF_COMPARE_B 8'h08
`define ATCS_OFF_CTRL_A 8'h0c
`define ATCS_OFF_CTRL_B 8'h10
`define ATCS_OFF_STATUS 8'h14
`define ATCS_OFF_GEN_CTRL 8'h18
`define ATCS_OFF_FLAGS 8'h1c
`define ATCS_OFF_IRQ_EN 8'h20

////////////////////////////////////////////////////////////////////////////////
// async_status_register fields
`define ATCS_ST_CTRL_B_BUSY 0
`define ATCS_ST_CTRL_A_BUSY 1
`define ATCS_ST_CMP_B_BUSY 2
`define ATCS_ST_CMP_A_BUSY 3
`define ATCS_ST_CNT_BUSY 4
`define ATCS_ST_ASYNC_SEL 5

// general_timer_control fields
`define ATCS_GC_PRESC_RST 0

// flag and irq enable fields
`define ATCS_FL_OVF 0
`define ATCS_FL_CMP_A 1
`define ATCS_FL_CMP_B 2

// timer_control_regs fields
`define ATCS_CA_COM_HI 7
`define ATCS_CA_COM_LO 6
`define ATCS_CA_CTC 1
`define ATCS_CB_CS_HI 2
`define ATCS_CB_CS_LO 0

// compare output actions
`define ATCS_COM_TOGGLE 2'h1
`define ATCS_COM_CLEAR 2'h2
`define ATCS_COM_SET 2'h3

////////////////////////////////////////////////////////////////////////////////
// reset values and timing
`define ATCS_RST_BYTE 8'h00
`define ATCS_OSC_EDGES 2'h2
`define ATCS_FLAG_SYNC_STAGES 3
`define ATCS_PRESC_W 10

`endif

// File: design/atcs_prescaler.v
/*
  prescaler: counts source enables and gives a timer tick at the selected
  division (stop, 1, 8, 32, 64, 128, 256, 1024).
  assumes: clock, synchronised reset and source enable come from the top.
*/
`timescale 1ns/1ps
`include "atcs_regs.vh"

module atcs_prescaler
(
  input wire clk_in,
  input wire rst_n_in,
  input wire src_en_in,
  input wire clr_in,
  input wire [2:0] sel_in,
  output wire tick_out
);

  reg [`ATCS_PRESC_W-1:0] count_q;
  wire [`ATCS_PRESC_W-1:0] mask;

  function [`ATCS_PRESC_W-1:0] div_mask;
    input [2:0] sel;
    begin
      case (sel)
        3'h2: div_mask = 10'h007;
        3'h3: div_mask = 10'h01f;
        3'h4: div_mask = 10'h03f;
        3'h5: div_mask = 10'h07f;
        3'h6: div_mask = 10'h0ff;
        3'h7: div_mask = 10'h3ff;
        default: div_mask = 10'h000;
      endcase
    end
  endfunction

  assign mask = div_mask(sel_in);
  assign tick_out = src_en_in & (sel_in != 3'h0) & ((count_q & mask) == mask);

  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      count_q <= 10'h000;
    end
    else if (clr_in)
    begin
      count_q <= 10'h000;
    end
    else if (src_en_in)
    begin
      count_q <= count_q + 10'h001;
    end
  end

endmodule

// File: design/atcs_hold.v
/*
  holding register with update-busy flag for one timer register.
  synchronous mode writes straight through; asynchronous mode parks the
  value and moves it after two oscillator rising edges.
  assumes: osc_edge_in is a one-cycle pulse per oscillator rising edge.
*/
`timescale 1ns/1ps
`include "atcs_regs.vh"

module atcs_hold
#(
  parameter W = 8
)
(
  input wire clk_in,
  input wire rst_n_in,
  input wire lost_in,
  input wire wr_in,
  input wire [W-1:0] wdata_in,
  input wire async_in,
  input wire osc_edge_in,
  output wire [W-1:0] value_out,
  output wire busy_out,
  output wire xfer_out
);

  reg [W-1:0] value_q;
  reg [W-1:0] held_q;
  reg busy_q;
  reg [1:0] edges_q;
  reg xfer_q;

  assign value_out = value_q;
  assign busy_out = busy_q;
  assign xfer_out = xfer_q;

  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      value_q <= {W{1'b0}};
      held_q <= {W{1'b0}};
      busy_q <= 1'b0;
      edges_q <= 2'h0;
      xfer_q <= 1'b0;
    end
    else
    begin
      xfer_q <= 1'b0;
      if (lost_in)
      begin
        value_q <= {W{1'b0}};
        held_q <= {W{1'b0}};
        busy_q <= 1'b0;
        edges_q <= 2'h0;
      end
      else if (wr_in)
      begin
        if (async_in)
        begin
          held_q <= wdata_in;
          busy_q <= 1'b1;
          edges_q <= 2'h0;
        end
        else
        begin
          value_q <= wdata_in;
          xfer_q <= 1'b1;
        end
      end
      else if (busy_q && osc_edge_in)
      begin
        if (edges_q == `ATCS_OSC_EDGES - 2'h1)
        begin
          value_q <= held_q;
          busy_q <= 1'b0;
          xfer_q <= 1'b1;
        end
        else
        begin
          edges_q <= edges_q + 2'h1;
        end
      end
    end
  end

endmodule

// File: tb/atcs_top_sva.sv
/*
  checker for the timer clock sync block: port-level timing of the oscillator
  enables, held writes, read answers, compare pin and wake request.
  assumes: bound to atcs_top; one core clock; nrst_in low resets everything.
*/
`timescale 1ns/1ps
module atcs_top_sva
(
  input wire core_clk_in,
  input wire nrst_in,
  input wire [7:0] addr_in,
  input wire [7:0] wr_data_in,
  input wire wr_in,
  input wire rd_in,
  input wire [7:0] rd_data_out,
  input wire osc_input_pin_in,
  input wire sleep_in,
  input wire power_down_in,
  input wire osc_enable_out,
  input wire port_detach_out,
  input wire compare_out,
  input wire wake_out
);
  reg pin_q;
  reg [7:0] osc_age_q;

  ////////////////////////////////////////////////////////////////////////////
  // cycles since the last rising pin level; saturates so it never wraps
  always @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      pin_q <= 1'b0;
      osc_age_q <= 8'hff;
    end
    else
    begin
      pin_q <= osc_input_pin_in;
      if (osc_input_pin_in && !pin_q)
        osc_age_q <= 8'h00;
      else if (osc_age_q != 8'hff)
        osc_age_q <= osc_age_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  chk_default_src: assert property ($rose(nrst_in) |-> !port_detach_out && !osc_enable_out)
    else $error("source not the core clock after reset");
  chk_pins_detach: assert property (wr_in && addr_in == 8'h14 && wr_data_in[5] |-> ##[1:3] port_detach_out)
    else $error("pins not detached after async select");
  chk_osc_pd_stop: assert property (power_down_in |=> !osc_enable_out)
    else $error("oscillator runs in power-down");
  chk_osc_running: assert property (port_detach_out && !$past(power_down_in) |-> osc_enable_out)
    else $error("oscillator stopped outside power-down");
  chk_busy_on_write: assert property (port_detach_out && wr_in && addr_in == 8'h04
    ##2 rd_in && addr_in == 8'h14 |=> rd_data_out[3])
    else $error("busy flag not set by held write");
  chk_sync_write: assert property (!port_detach_out && wr_in && addr_in == 8'h04
    ##2 rd_in && addr_in == 8'h04 |=> rd_data_out == $past(wr_data_in, 3))
    else $error("sync write not visible");
  chk_presc_rd_zero: assert property (rd_in && addr_in == 8'h18 |=> rd_data_out == 8'h00)
    else $error("prescaler reset bit reads nonzero");
  chk_cmp_on_tick: assert property (port_detach_out && $changed(compare_out) && !power_down_in
    && !$past(power_down_in) |-> osc_age_q <= 8'h08)
    else $error("compare pin moved away from a timer edge");
  chk_wake_on_tick: assert property (port_detach_out && $rose(wake_out) |-> osc_age_q <= 8'h08)
    else $error("wake raised away from a timer edge");
endmodule

bind atcs_top atcs_top_sva chk (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
  .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
  .osc_input_pin_in(osc_input_pin_in), .sleep_in(sleep_in), .power_down_in(power_down_in),
  .osc_enable_out(osc_enable_out), .port_detach_out(port_detach_out),
  .compare_out(compare_out), .wake_out(wake_out));

// File: tb/atcs_osc_model.sv
/*
  watch crystal model: square wave on the oscillator pin while enabled.
  assumes: run_in is the block's oscillator enable; time unit 1 ns.
*/
`timescale 1ns/1ps
module atcs_osc_model
#(
  parameter HALF_NS = 83
)
(
  input wire run_in,
  output reg pin_out
);
  // half period not a multiple of the core period, so phase drifts;
  // the half-nanosecond phase keeps pin changes off every clock and bench step
  initial
  begin
    pin_out = 1'b0;
    #0.5;
    forever
    begin
      #(HALF_NS);
      if (run_in)
        pin_out = ~pin_out;
      else
        pin_out = 1'b0;
    end
  end
endmodule

// File: tb/atcs_top_tb.sv
/*
  self-checking bench for the timer clock sync block.
  assumes: atcs_top with its register map; crystal model on the pin.
*/
`timescale 1ns/1ps
`define CHECK(got, exp) \
  begin \
    n_tests = n_tests + 1; \
    if ((got) !== (exp)) \
    begin \
      n_fail = n_fail + 1; \
      $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module atcs_top_tb;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg [7:0] addr = 8'h00;
  reg [7:0] wdata = 8'h00;
  reg wr_s = 1'b0;
  reg rd_s = 1'b0;
  reg sleep = 1'b0;
  reg pd = 1'b0;
  wire [7:0] rdata;
  wire osc_pin, osc_en, detach, cmp, wake;
  integer n_fail = 0;
  integer n_tests = 0;
  integer i;
  reg [7:0] c0, c1;

  always #4 clk = ~clk;

  atcs_top uut (.core_clk_in(clk), .nrst_in(nrst), .addr_in(addr), .wr_data_in(wdata),
    .wr_in(wr_s), .rd_in(rd_s), .rd_data_out(rdata), .osc_input_pin_in(osc_pin),
    .sleep_in(sleep), .power_down_in(pd), .osc_enable_out(osc_en),
    .port_detach_out(detach), .compare_out(cmp), .wake_out(wake));
  atcs_osc_model xtal (.run_in(osc_en), .pin_out(osc_pin));

  ////////////////////////////////////////////////////////////////////////////
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  end
  endtask

  task rd(input [7:0] a, output [7:0] d);
  begin
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdata;
  end
  endtask

  task rd_chk(input [7:0] a, input [7:0] e);
    reg [7:0] d;
  begin
    rd(a, d);
    `CHECK(d, e)
  end
  endtask

  // waits past n oscillator rises plus the pin sampling delay
  task osc_wait(input integer n);
  begin
    repeat (n) @(posedge osc_pin);
    repeat (8) @(posedge clk);
  end
  endtask

  task final_report;
  begin
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task t_defaults;
  begin
    rd_chk(8'h14, 8'h00);
    `CHECK(detach, 1'b0)
    `CHECK(osc_en, 1'b0)
    wr(8'h18, 8'h01);
    rd_chk(8'h18, 8'h00);
    rd_chk(8'h24, 8'h00);
  end
  endtask

  task t_sync;
  begin
    wr(8'h04, 8'h5a);
    rd_chk(8'h04, 8'h5a);
    wr(8'h08, 8'ha5);
    rd_chk(8'h08, 8'ha5);
    rd_chk(8'h04, 8'h5a);
  end
  endtask

  // four periods of each division; a wrong divisor lands outside 3..6
  task t_presc;
    integer div [0:7];
  begin
    div[0] = 1; div[1] = 1; div[2] = 8; div[3] = 32;
    div[4] = 64; div[5] = 128; div[6] = 256; div[7] = 1024;
    for (i = 0; i < 8; i = i + 1)
    begin
      wr(8'h10, 8'h00);
      wr(8'h00, 8'h00);
      wr(8'h18, 8'h01);
      wr(8'h10, i[7:0]);
      repeat (div[i] * 4) @(posedge clk);
      rd(8'h00, c0);
      if (i == 0)
        `CHECK(c0, 8'h00)
      else
        `CHECK(c0 >= 8'h03 && c0 <= 8'h06, 1'b1)
    end
    wr(8'h10, 8'h00);
  end
  endtask

  task t_async;
  begin
    wr(8'h14, 8'h20);
    // start the held writes just after a rise so both see the same edges
    osc_wait(1);
    `CHECK(detach, 1'b1)
    `CHECK(osc_en, 1'b1)
    wr(8'h08, 8'h44);
    wr(8'h04, 8'h33);
    rd_chk(8'h14, 8'h2c);
    rd_chk(8'h04, 8'h5a);
    osc_wait(1);
    rd_chk(8'h14, 8'h2c);
    osc_wait(1);
    rd_chk(8'h14, 8'h20);
    rd_chk(8'h04, 8'h33);
    rd_chk(8'h08, 8'h44);
    wr(8'h1c, 8'h07);
  end
  endtask

  task t_cmp_wake;
  begin
    wr(8'h0c, 8'h40);
    wr(8'h04, 8'h03);
    wr(8'h20, 8'h02);
    wr(8'h00, 8'h00);
    wr(8'h10, 8'h01);
    osc_wait(2);
    rd_chk(8'h14, 8'h20);
    for (i = 0; i < 400 && cmp !== 1'b1; i = i + 1)
      @(posedge clk);
    `CHECK(cmp, 1'b1)
    repeat (30) @(posedge clk);
    `CHECK(wake, 1'b1)
    // sleeping again with the flag still pending must keep the wake request
    sleep <= 1'b1;
    repeat (2) @(posedge clk);
    `CHECK(wake, 1'b1)
    sleep <= 1'b0;
    rd_chk(8'h1c, 8'h02);
    wr(8'h1c, 8'h02);
    repeat (3) @(posedge clk);
    `CHECK(wake, 1'b0)
  end
  endtask

  task t_sleep;
  begin
    osc_wait(1);
    rd(8'h00, c0);
    rd_chk(8'h14, 8'h20);
    @(posedge clk);
    sleep <= 1'b1;
    repeat (60) @(posedge clk);
    osc_wait(1);
    @(posedge clk);
    sleep <= 1'b0;
    rd(8'h00, c1);
    `CHECK(c1, c0)
    wr(8'h0c, 8'h40);
    osc_wait(2);
    rd_chk(8'h14, 8'h20);
    rd(8'h00, c1);
    `CHECK(c1 != c0, 1'b1)
  end
  endtask

  task t_pdown;
  begin
    @(posedge clk);
    pd <= 1'b1;
    repeat (3) @(posedge clk);
    `CHECK(osc_en, 1'b0)
    `CHECK(detach, 1'b1)
    pd <= 1'b0;
    repeat (3) @(posedge clk);
    `CHECK(osc_en, 1'b1)
    // short stand-in for the oscillator start-up settling wait
    osc_wait(2);
    rd_chk(8'h04, 8'h00);
    rd_chk(8'h0c, 8'h00);
    rd_chk(8'h10, 8'h00);
  end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_defaults;
    t_sync;
    t_presc;
    t_async;
    t_cmp_wake;
    t_sleep;
    t_pdown;
    final_report;
  end

  // the division sweep dominates, about 6100 cycles
  initial
  begin
    repeat (40000) @(posedge clk);
    n_fail = n_fail + 1;
    final_report;
  end
endmodule
